// ### hdl/crc_console.sv
// console command interpreter for floating-point and status word access
//
// Summary of operation
// - after single examine, '=' starts modify; keeps last eight hex digits
// - cr ends single modify: write register, then cr, lf, prompt
// - single-precision value stored as typed, no normalization check
// - D selects double register; without double hardware answer '?'
// - cr ends number entry; low four bits give double register number
// - odd double register number is rounded down to even
// - show whole 64-bit double register, then cr, lf, prompt
// - plus and minus are invalid with a floating register selected
// - double modify keeps only the last 16 hex digits typed
// - cr ends double modify: write 64 bits, then cr, lf, prompt
// - double-precision value stored without normalization check
// - P enters status word display, acts on following cr
// - on that cr show status word, then cr, lf, prompt
// - plus and minus are invalid with status word selected
// - after status examine, '=' modifies status; keeps last six digits
// - cr ends status modify: load, redisplay, then cr, lf, prompt
// - terminal interface answers at two fixed device addresses
// - at console start program terminal for highest rate, same framing
// - '<' starts program execution at the location counter
// - invalid character gives '?', cr, lf and a new prompt
// - spaces in any command are ignored
`timescale 1ns/1ns
module crc_console
  import crc_pkg::*;
(
  // clock and reset
  input  wire logic          clock_in,
  input  wire logic          rst_in,
  // console start after power-up or initialize
  input  wire logic          start_in,
  // hardware present straps
  input  wire logic          has_sp_in,
  input  wire logic          has_dp_in,
  // received characters
  input  wire logic          rx_valid_in,
  input  wire logic [6:0]    rx_char_in,
  output logic               rx_ready_out,
  // transmitted characters
  output logic               tx_valid_out,
  output logic [6:0]         tx_char_out,
  input  wire logic          tx_ready_in,
  // terminal interface programming
  output crc_term_cfg_t      term_cfg_out,
  // floating-point register file
  output crc_fpr_rd_t        fpr_rd_out,
  input  wire logic [63:0]   fpr_rd_data_in,
  output crc_fpr_wr_t        fpr_wr_out,
  // program status word and location counter
  input  wire logic [23:0]   psw_status_in,
  input  wire logic [23:0]   loc_in,
  output crc_psw_wr_t        psw_wr_out,
  // start program execution
  output logic               run_out
);

  crc_regs_t  st_r;
  crc_regs_t  st_nxt;
  logic       rx_is_hex;
  logic [3:0] rx_val;
  logic [6:0] tx_asc;
  logic       busy;
  logic       take;

  crc_hexconv u_hexconv (
    .char_in    (rx_char_in),
    .nib_in     (st_r.show[63:60]),
    .is_hex_out (rx_is_hex),
    .val_out    (rx_val),
    .asc_out    (tx_asc)
  );

  // a character still waiting for the terminal holds the sequencer
  assign busy = st_r.tx_valid & ~tx_ready_in;
  assign take = rx_valid_in & st_r.rx_ready;

  always_comb begin
    st_nxt              = st_r;
    st_nxt.tx_valid     = busy;
    st_nxt.run          = 1'b0;
    st_nxt.fpr_wr.en    = 1'b0;
    st_nxt.psw_wr.en    = 1'b0;
    st_nxt.cfg.valid    = 1'b0;

    unique case (st_r.state)
      S_IDLE: begin
        if (take) begin
          if (rx_char_in == CH_SPACE) begin
            // spaces leave every mode untouched
            st_nxt.state = S_IDLE;
          end else if (rx_char_in == CH_CR) begin
            st_nxt.mode = M_CMD;
            if (st_r.mode == M_NUM) begin
              if (st_r.kind == K_PSW) begin
                st_nxt.show      = {psw_status_in, loc_in, 16'h0000};
                st_nxt.digits    = STATUS_DIGITS;
                st_nxt.gap       = 1'b1;
                st_nxt.body_pend = 1'b1;
                st_nxt.examined  = 1'b1;
                st_nxt.state     = S_CR;
              end else begin
                // low nibble only, forced even
                st_nxt.regnum     = st_r.acc[3:0] & EVEN_MASK;
                st_nxt.fpr_rd.idx = st_r.acc[3:0] & EVEN_MASK;
                st_nxt.fpr_rd.dbl = (st_r.kind == K_DP);
                st_nxt.state      = S_RDWAIT;
              end
            end else if (st_r.mode == M_DATA) begin
              st_nxt.examined  = 1'b0;
              st_nxt.body_pend = 1'b0;
              st_nxt.state     = S_CR;
              unique case (st_r.kind)
                K_SP: begin
                  // no normalization test, raw bits go in
                  st_nxt.fpr_wr.en   = 1'b1;
                  st_nxt.fpr_wr.dbl  = 1'b0;
                  st_nxt.fpr_wr.idx  = st_r.regnum;
                  st_nxt.fpr_wr.data = {32'h0000_0000,
                                        st_r.acc[31:0]};
                end
                K_DP: begin
                  st_nxt.fpr_wr.en   = 1'b1;
                  st_nxt.fpr_wr.dbl  = 1'b1;
                  st_nxt.fpr_wr.idx  = st_r.regnum;
                  st_nxt.fpr_wr.data = st_r.acc;
                end
                K_PSW: begin
                  st_nxt.psw_wr.en     = 1'b1;
                  st_nxt.psw_wr.status = st_r.acc[23:0];
                  // redisplay what was loaded, not the old status
                  st_nxt.show      = {st_r.acc[23:0], loc_in, 16'h0000};
                  st_nxt.digits    = STATUS_DIGITS;
                  st_nxt.gap       = 1'b1;
                  st_nxt.body_pend = 1'b1;
                end
                K_NONE: begin
                  st_nxt.state = S_QMARK;
                end
              endcase
            end else begin
              // bare cr just gives a fresh prompt
              st_nxt.examined  = 1'b0;
              st_nxt.body_pend = 1'b0;
              st_nxt.state     = S_CR;
            end
          end else if (rx_is_hex && st_r.mode != M_CMD) begin
            // older digits fall off the top of the accumulator
            st_nxt.acc = {st_r.acc[59:0], rx_val};
          end else if (st_r.mode != M_CMD) begin
            st_nxt.mode     = M_CMD;
            st_nxt.examined = 1'b0;
            st_nxt.state    = S_QMARK;
          end else if (rx_char_in == CH_EQUAL && st_r.examined &&
                       st_r.kind != K_NONE) begin
            st_nxt.mode = M_DATA;
            st_nxt.acc  = 64'h0000_0000_0000_0000;
          end else if (rx_char_in == CH_SPREG && has_sp_in) begin
            st_nxt.mode     = M_NUM;
            st_nxt.kind     = K_SP;
            st_nxt.examined = 1'b0;
            st_nxt.acc      = 64'h0000_0000_0000_0000;
          end else if (rx_char_in == CH_DPREG && has_dp_in) begin
            st_nxt.mode     = M_NUM;
            st_nxt.kind     = K_DP;
            st_nxt.examined = 1'b0;
            st_nxt.acc      = 64'h0000_0000_0000_0000;
          end else if (rx_char_in == CH_STATUS) begin
            st_nxt.mode     = M_NUM;
            st_nxt.kind     = K_PSW;
            st_nxt.examined = 1'b0;
            st_nxt.acc      = 64'h0000_0000_0000_0000;
          end else if (rx_char_in == CH_PROMPT) begin
            // execution takes over; no prompt is printed, but later characters are still taken
            st_nxt.run      = 1'b1;
            st_nxt.examined = 1'b0;
          end else begin
            // stepping is never legal here, nor any other character
            st_nxt.examined = 1'b0;
            st_nxt.state    = S_QMARK;
          end
        end
      end

      S_CFG: begin
        st_nxt.cfg.valid       = 1'b1;
        st_nxt.cfg.addr_a      = TERM_ADDR_A;
        st_nxt.cfg.addr_b      = TERM_ADDR_B;
        st_nxt.cfg.rate        = TERM_RATE_MAX;
        st_nxt.cfg.data_bits   = TERM_DATA_BITS;
        st_nxt.cfg.stop_bits   = TERM_STOP_BITS;
        st_nxt.cfg.parity_even = 1'b1;
        st_nxt.show      = {psw_status_in, loc_in, 16'h0000};
        st_nxt.digits    = STATUS_DIGITS;
        st_nxt.gap       = 1'b1;
        st_nxt.body_pend = 1'b1;
        st_nxt.state     = S_CR;
      end

      S_RDWAIT: begin
        st_nxt.examined  = 1'b1;
        st_nxt.body_pend = 1'b1;
        st_nxt.gap       = 1'b0;
        st_nxt.state     = S_CR;
        if (st_r.kind == K_DP) begin
          st_nxt.show   = fpr_rd_data_in;
          st_nxt.digits = DP_DIGITS;
        end else begin
          st_nxt.show   = {fpr_rd_data_in[31:0], 32'h0000_0000};
          st_nxt.digits = SP_DIGITS;
        end
      end

      S_QMARK: begin
        if (!busy) begin
          st_nxt.tx_valid  = 1'b1;
          st_nxt.tx_char   = CH_QMARK;
          st_nxt.body_pend = 1'b0;
          st_nxt.state     = S_CR;
        end
      end

      S_CR: begin
        if (!busy) begin
          st_nxt.tx_valid = 1'b1;
          st_nxt.tx_char  = CH_CR;
          st_nxt.state    = S_LF;
        end
      end

      S_LF: begin
        if (!busy) begin
          st_nxt.tx_valid = 1'b1;
          st_nxt.tx_char  = CH_LF;
          if (st_r.body_pend) begin
            st_nxt.body_pend = 1'b0;
            st_nxt.state     = S_HEX;
          end else begin
            st_nxt.state = S_PROMPT;
          end
        end
      end

      S_HEX: begin
        if (!busy) begin
          st_nxt.tx_valid = 1'b1;
          st_nxt.tx_char  = tx_asc;
          st_nxt.show     = {st_r.show[59:0], 4'h0};
          st_nxt.digits   = st_r.digits - 5'h01;
          if (st_r.digits == 5'h01) begin
            st_nxt.state = S_CR;
          end else if (st_r.gap && st_r.digits == STATUS_GAP_AT) begin
            // status and location counter print as two groups
            st_nxt.state = S_SPACE;
          end
        end
      end

      S_SPACE: begin
        if (!busy) begin
          st_nxt.tx_valid = 1'b1;
          st_nxt.tx_char  = CH_SPACE;
          st_nxt.state    = S_HEX;
        end
      end

      S_PROMPT: begin
        if (!busy) begin
          st_nxt.tx_valid = 1'b1;
          st_nxt.tx_char  = CH_PROMPT;
          st_nxt.state    = S_IDLE;
        end
      end

      default: begin
        st_nxt.state = S_IDLE;
      end
    endcase

    // a start restarts the console from any state
    if (start_in) begin
      st_nxt.state    = S_CFG;
      st_nxt.mode     = M_CMD;
      st_nxt.kind     = K_NONE;
      st_nxt.examined = 1'b0;
    end

    // characters are taken only while the sequencer is silent
    st_nxt.rx_ready = (st_nxt.state == S_IDLE);
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rx_ready_out = st_r.rx_ready;
  assign tx_valid_out = st_r.tx_valid;
  assign tx_char_out  = st_r.tx_char;
  assign term_cfg_out = st_r.cfg;
  assign fpr_rd_out   = st_r.fpr_rd;
  assign fpr_wr_out   = st_r.fpr_wr;
  assign psw_wr_out   = st_r.psw_wr;
  assign run_out      = st_r.run;

endmodule : crc_console

// ### hdl/crc_pkg.sv
// shared constants, states and carrier types of the console command interpreter
package crc_pkg;

  // ascii characters seen or sent by the interpreter (7-bit framing)
  localparam logic [6:0] CH_CR     = 7'h0d;
  localparam logic [6:0] CH_LF     = 7'h0a;
  localparam logic [6:0] CH_SPACE  = 7'h20;
  localparam logic [6:0] CH_QMARK  = 7'h3f;
  localparam logic [6:0] CH_PROMPT = 7'h3c;
  localparam logic [6:0] CH_EQUAL  = 7'h3d;
  localparam logic [6:0] CH_PLUS   = 7'h2b;
  localparam logic [6:0] CH_MINUS  = 7'h2d;
  localparam logic [6:0] CH_SPREG  = 7'h46;
  localparam logic [6:0] CH_DPREG  = 7'h44;
  localparam logic [6:0] CH_STATUS = 7'h50;

  // terminal interface addresses and character framing
  localparam logic [15:0] TERM_ADDR_A    = 16'h0010;
  localparam logic [15:0] TERM_ADDR_B    = 16'h0011;
  localparam logic [3:0]  TERM_RATE_MAX  = 4'hf;
  localparam logic [3:0]  TERM_DATA_BITS = 4'h7;
  localparam logic [1:0]  TERM_STOP_BITS = 2'h2;

  // digits shown per register kind
  localparam logic [4:0]  SP_DIGITS      = 5'h08;
  localparam logic [4:0]  DP_DIGITS      = 5'h10;
  localparam logic [4:0]  STATUS_DIGITS  = 5'h0c;
  localparam logic [4:0]  STATUS_GAP_AT  = 5'h07;
  localparam logic [3:0]  EVEN_MASK      = 4'he;

  typedef enum logic [3:0] {
    S_IDLE   = 4'b0000,
    S_CFG    = 4'b0001,
    S_RDWAIT = 4'b0010,
    S_QMARK  = 4'b0011,
    S_CR     = 4'b0100,
    S_LF     = 4'b0101,
    S_HEX    = 4'b0110,
    S_SPACE  = 4'b0111,
    S_PROMPT = 4'b1000
  } crc_state_t;

  typedef enum logic [1:0] {
    M_CMD  = 2'b00,
    M_NUM  = 2'b01,
    M_DATA = 2'b10
  } crc_mode_t;

  typedef enum logic [1:0] {
    K_NONE = 2'b00,
    K_SP   = 2'b01,
    K_DP   = 2'b10,
    K_PSW  = 2'b11
  } crc_kind_t;

  typedef struct packed {
    logic        en;
    logic        dbl;
    logic [3:0]  idx;
    logic [63:0] data;
  } crc_fpr_wr_t;

  typedef struct packed {
    logic       dbl;
    logic [3:0] idx;
  } crc_fpr_rd_t;

  typedef struct packed {
    logic        en;
    logic [23:0] status;
  } crc_psw_wr_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr_a;
    logic [15:0] addr_b;
    logic [3:0]  rate;
    logic [3:0]  data_bits;
    logic [1:0]  stop_bits;
    logic        parity_even;
  } crc_term_cfg_t;

  typedef struct packed {
    crc_state_t    state;
    crc_mode_t     mode;
    crc_kind_t     kind;
    logic          examined;
    logic [63:0]   acc;
    logic [3:0]    regnum;
    logic [63:0]   show;
    logic [4:0]    digits;
    logic          gap;
    logic          body_pend;
    logic          tx_valid;
    logic [6:0]    tx_char;
    logic          rx_ready;
    logic          run;
    crc_fpr_wr_t   fpr_wr;
    crc_fpr_rd_t   fpr_rd;
    crc_psw_wr_t   psw_wr;
    crc_term_cfg_t cfg;
  } crc_regs_t;

endpackage : crc_pkg

// ### hdl/crc_hexconv.sv
// ascii to hex digit decode and hex digit to ascii encode
`timescale 1ns/1ns
module crc_hexconv
  import crc_pkg::*;
(
  // character to classify and nibble to encode
  input  logic [6:0] char_in,
  input  logic [3:0] nib_in,
  // results
  output logic       is_hex_out,
  output logic [3:0] val_out,
  output logic [6:0] asc_out
);

  always_comb begin
    is_hex_out = 1'b0;
    val_out    = 4'h0;
    if (char_in >= 7'h30 && char_in <= 7'h39) begin
      is_hex_out = 1'b1;
      val_out    = char_in[3:0];
    end else if ((char_in >= 7'h41 && char_in <= 7'h46) ||
                 (char_in >= 7'h61 && char_in <= 7'h66)) begin
      // letters a..f map to 10..15, either case
      is_hex_out = 1'b1;
      val_out    = char_in[3:0] + 4'h9;
    end
  end

  always_comb begin
    if (nib_in < 4'ha) begin
      asc_out = 7'h30 + {3'h0, nib_in};
    end else begin
      asc_out = 7'h37 + {3'h0, nib_in};
    end
  end

endmodule : crc_hexconv

// ### bench/crc_console_chk.sv
// port assertions for the console command interpreter
`timescale 1ns/1ns
module crc_console_chk
  import crc_pkg::*;
(
  // clock and reset
  input  wire logic          clock_in,
  input  wire logic          rst_in,
  // watched ports
  input  wire logic          start_in,
  input  wire logic          rx_valid_in,
  input  wire logic [6:0]    rx_char_in,
  input  wire logic          rx_ready_out,
  input  wire logic          tx_valid_out,
  input  wire logic [6:0]    tx_char_out,
  input  wire logic          tx_ready_in,
  input  wire crc_term_cfg_t term_cfg_out,
  input  wire crc_fpr_rd_t   fpr_rd_out,
  input  wire crc_fpr_wr_t   fpr_wr_out,
  input  wire crc_psw_wr_t   psw_wr_out,
  input  wire logic          run_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic take;
  assign take = rx_valid_in && rx_ready_out;

  run_cause_a: assert property (
    run_out |-> $past(take && rx_char_in == CH_PROMPT))
    else $error("run pulse without a taken prompt char");
  step_refused_a: assert property (
    take && (rx_char_in == CH_PLUS || rx_char_in == CH_MINUS)
    |-> ##2 tx_valid_out && tx_char_out == CH_QMARK)
    else $error("step char not answered with question mark");
  space_ignored_a: assert property (
    take && rx_char_in == CH_SPACE |=> rx_ready_out && !tx_valid_out)
    else $error("space char started a reply");
  term_addr_a: assert property (
    term_cfg_out.valid |-> term_cfg_out.addr_a == TERM_ADDR_A
      && term_cfg_out.addr_b == TERM_ADDR_B)
    else $error("terminal addresses wrong");
  term_setup_a: assert property (
    term_cfg_out.valid |-> ($past(start_in) || $past(start_in, 2))
      && term_cfg_out.rate == TERM_RATE_MAX
      && term_cfg_out.data_bits == TERM_DATA_BITS
      && term_cfg_out.stop_bits == TERM_STOP_BITS
      && term_cfg_out.parity_even)
    else $error("terminal setup wrong or unprompted");
  sp_upper_zero_a: assert property (
    fpr_wr_out.en && !fpr_wr_out.dbl
    |-> fpr_wr_out.data[63:32] == 32'h0000_0000)
    else $error("single write carries upper bits");
  even_index_a: assert property (
    !fpr_rd_out.idx[0] && !(fpr_wr_out.en && fpr_wr_out.idx[0]))
    else $error("odd floating register index");
  fpr_write_cause_a: assert property (
    fpr_wr_out.en |-> $past(take && rx_char_in == CH_CR))
    else $error("register write without carriage return");
  psw_write_cause_a: assert property (
    psw_wr_out.en |-> $past(take && rx_char_in == CH_CR)
      ##[1:4] tx_valid_out && tx_char_out == CH_CR)
    else $error("status write not tied to carriage return");
  tx_hold_a: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_char_out))
    else $error("printed char dropped before taken");
endmodule : crc_console_chk

bind crc_console crc_console_chk u_chk (
  .clock_in     (clock_in),
  .rst_in       (rst_in),
  .start_in     (start_in),
  .rx_valid_in  (rx_valid_in),
  .rx_char_in   (rx_char_in),
  .rx_ready_out (rx_ready_out),
  .tx_valid_out (tx_valid_out),
  .tx_char_out  (tx_char_out),
  .tx_ready_in  (tx_ready_in),
  .term_cfg_out (term_cfg_out),
  .fpr_rd_out   (fpr_rd_out),
  .fpr_wr_out   (fpr_wr_out),
  .psw_wr_out   (psw_wr_out),
  .run_out      (run_out)
);

// ### bench/crc_term_model.sv
// operator terminal model: types characters and collects the replies
`timescale 1ns/1ns
module crc_term_model
  import crc_pkg::*;
(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  // pacing: refuse every other cycle when high
  input  wire logic       slow_in,
  // characters typed
  output logic            rx_valid_out,
  output logic [6:0]      rx_char_out,
  input  wire logic       rx_ready_in,
  // characters printed
  input  wire logic       tx_valid_in,
  input  wire logic [6:0] tx_char_in,
  output logic            tx_ready_out
);
  logic [6:0] got [$];

  initial begin
    rx_valid_out = 1'b0;
    rx_char_out  = 7'h00;
    tx_ready_out = 1'b0;
  end

  // full duplex 7-bit chars: printing accepted while typing
  always @(posedge clock_in) begin
    tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
    if (tx_valid_in && tx_ready_out && !rst_in)
      got.push_back(tx_char_in);
  end

  task automatic send(input logic [6:0] c);
    int n;
    n = 0;
    rx_valid_out = 1'b1;
    rx_char_out  = c;
    do begin
      @(posedge clock_in);
      n++;
    end while (!rx_ready_in && n < 500);
    // valid stays up so the next char replaces this one without a gap
    #1;
  endtask : send

  task automatic idle();
    rx_valid_out = 1'b0;
    // a released line never shows a stale copy
    rx_char_out  = ~rx_char_out;
  endtask : idle
endmodule : crc_term_model

// ### bench/tb_top.sv
// self-checking bench for the console command interpreter
`timescale 1ns/1ns
module tb_top;
  import crc_pkg::*;
  logic          clock_in  = 1'b0;
  logic          rst_in    = 1'b1;
  logic          start_in  = 1'b0;
  logic          has_dp_in = 1'b0;
  logic          slow      = 1'b0;
  logic          rx_valid, rx_ready, tx_valid, tx_ready, run;
  logic [6:0]    rx_char, tx_char;
  crc_term_cfg_t cfg;
  crc_fpr_rd_t   rd;
  crc_fpr_wr_t   wr, wr_seen;
  crc_psw_wr_t   pw;
  logic [23:0]   processor_status_word = 24'h00_3000;
  logic [23:0]   loc = 24'h03_FB00;
  logic [63:0]   fpr [16];
  logic [6:0]    exp_q [$];
  int            bad_count = 0, check_count = 0, cycles = 0, run_cnt = 0;

  always #20 clock_in = ~clock_in;

  crc_console u_crc_console (
    .clock_in(clock_in), .rst_in(rst_in), .start_in(start_in),
    .has_sp_in(1'b1), .has_dp_in(has_dp_in),
    .rx_valid_in(rx_valid), .rx_char_in(rx_char), .rx_ready_out(rx_ready),
    .tx_valid_out(tx_valid), .tx_char_out(tx_char), .tx_ready_in(tx_ready),
    .term_cfg_out(cfg), .fpr_rd_out(rd), .fpr_rd_data_in(fpr[rd.idx]),
    .fpr_wr_out(wr), .psw_status_in(processor_status_word), .loc_in(loc),
    .psw_wr_out(pw), .run_out(run));

  crc_term_model u_term (
    .clock_in(clock_in), .rst_in(rst_in), .slow_in(slow),
    .rx_valid_out(rx_valid), .rx_char_out(rx_char), .rx_ready_in(rx_ready),
    .tx_valid_in(tx_valid), .tx_char_in(tx_char), .tx_ready_out(tx_ready));

  // register file and status word behind the interpreter
  always @(posedge clock_in) begin
    if (wr.en) begin
      fpr[wr.idx] <= wr.data;
      wr_seen     <= wr;
    end
    if (pw.en)
      processor_status_word <= pw.status;
    if (run)
      run_cnt++;
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [71:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [6:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? 7'h30 + n : 7'h37 + n;
  endfunction : hexc

  task automatic push_hex(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      exp_q.push_back(hexc(v[4*i+:4]));
  endtask : push_hex

  task automatic push_crlf();
    exp_q.push_back(CH_CR);
    exp_q.push_back(CH_LF);
  endtask : push_crlf

  // status then location, as the greeting shows them
  task automatic push_psw(input logic [23:0] v);
    push_crlf();
    push_hex(v, 6);
    exp_q.push_back(CH_SPACE);
    push_hex(loc, 6);
  endtask : push_psw

  task automatic push_tail(input logic qmark);
    if (qmark)
      exp_q.push_back(CH_QMARK);
    push_crlf();
    exp_q.push_back(CH_PROMPT);
  endtask : push_tail

  task automatic send_str(input string s);
    foreach (s[i])
      u_term.send(7'(s[i]));
    u_term.idle();
  endtask : send_str

  // waits bounded, then compares every printed char in order
  task automatic chk_reply(input string what);
    int n;
    n = 0;
    while (u_term.got.size() < exp_q.size() && n < 600) begin
      @(posedge clock_in);
      n++;
    end
    repeat (6) @(posedge clock_in);
    chk(u_term.got.size(), exp_q.size(), what);
    foreach (exp_q[i])
      if (i < u_term.got.size())
        chk(u_term.got[i], exp_q[i], what);
    u_term.got.delete();
    exp_q.delete();
    #1;
  endtask : chk_reply

  task automatic t_start();
    start_in = 1'b1;
    @(posedge clock_in);
    #1;
    start_in = 1'b0;
    push_psw(processor_status_word);
    push_tail(1'b0);
    chk_reply("greeting");
    chk(cfg.rate, TERM_RATE_MAX, "rate");
    chk({cfg.addr_a, cfg.addr_b}, {TERM_ADDR_A, TERM_ADDR_B}, "addr");
    chk({cfg.data_bits, cfg.stop_bits, cfg.parity_even},
        {TERM_DATA_BITS, TERM_STOP_BITS, 1'b1}, "framing");
  endtask : t_start

  task automatic t_sp();
    send_str("F 13\015");
    push_crlf();
    push_hex(fpr[2], 8);
    push_tail(1'b0);
    chk_reply("sp show");
    send_str("=123456789\015");
    push_tail(1'b0);
    chk_reply("sp modify");
    chk(wr_seen, {2'b10, 4'h2, 64'h0000_0000_2345_6789}, "sp write");
    slow = 1'b1;
    send_str("+");
    push_tail(1'b1);
    chk_reply("sp step");
    slow = 1'b0;
  endtask : t_sp

  task automatic t_dp();
    send_str("D");
    push_tail(1'b1);
    chk_reply("dp absent");
    has_dp_in = 1'b1;
    send_str("D17\015");
    push_crlf();
    push_hex(fpr[6], 16);
    push_tail(1'b0);
    chk_reply("dp show");
    send_str("=10123456789abcdef\015");
    push_tail(1'b0);
    chk_reply("dp modify");
    chk(wr_seen, {2'b11, 4'h6, 64'h0123_4567_89AB_CDEF}, "dp write");
    send_str("-");
    push_tail(1'b1);
    chk_reply("dp step");
  endtask : t_dp

  task automatic t_psw();
    send_str("P\015");
    push_psw(processor_status_word);
    push_tail(1'b0);
    chk_reply("psw show");
    send_str("=9876543\015");
    push_psw(24'h87_6543);
    push_tail(1'b0);
    chk_reply("psw modify");
    chk(processor_status_word, 24'h87_6543, "psw write");
    send_str("+");
    push_tail(1'b1);
    chk_reply("psw step");
  endtask : t_psw

  task automatic t_run();
    send_str("Z");
    push_tail(1'b1);
    chk_reply("bad char");
    send_str("<");
    chk_reply("run quiet");
    chk(run_cnt, 1, "run pulse");
  endtask : t_run

  initial begin
    for (int i = 0; i < 16; i++)
      fpr[i] = {16{4'(i)}};
    repeat (2) @(posedge clock_in);
    #1;
    rst_in = 1'b0;
    @(posedge clock_in);
    #1;
    t_start();
    t_sp();
    t_dp();
    t_psw();
    t_run();
    end_of_test();
  end
endmodule : tb_top
